// file: core/rtom_regs.vh
// Register offsets, field positions, reset values and timing constants
`ifndef RTOM_REGS_VH
`define RTOM_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RTOM_ADDR_W         12
`define RTOM_OBS_OFS        12'h064
`define RTOM_ETC_OFS        12'h06C

// ----------------------------------------------------------------
// Observation register fields
// ----------------------------------------------------------------
`define RTOM_WIN_LSB        28
`define RTOM_WIN_MSB        29
`define RTOM_SEL_LSB        16
`define RTOM_SEL_MSB        22
`define RTOM_OBS_WMASK      32'h307F0000
`define RTOM_OBS_RST        32'h00000000

// ----------------------------------------------------------------
// Timer control register fields
// ----------------------------------------------------------------
`define RTOM_ETC_WMASK      32'hD03F0000
`define RTOM_ETC_TRIG_BIT   24
`define RTOM_ETC_RST        32'h00000000
`define RTOM_ZCP_LSB        30
`define RTOM_ZCP_MSB        31
`define RTOM_ZSRC_BIT       28
`define RTOM_CMP_BIT        21
`define RTOM_IRQ_BIT        20
`define RTOM_DRV_BIT        19
`define RTOM_SMP_BIT        18
`define RTOM_EDGE_BIT       17
`define RTOM_RUN_BIT        16

// ----------------------------------------------------------------
// Observe select codes
// ----------------------------------------------------------------
`define RTOM_SEL_EXC        7'h44
`define RTOM_SEL_COS        7'h43
`define RTOM_SEL_SIN        7'h42
`define RTOM_SEL_CTLVAR     7'h2F
`define RTOM_SEL_SQINT      7'h2E
`define RTOM_SEL_SQSUM      7'h2D
`define RTOM_SEL_COSOFS     7'h1D
`define RTOM_SEL_SINOFS     7'h1C

// ----------------------------------------------------------------
// Timing: clock period and velocity windows in ps, window 0 also in clock cycles
// ----------------------------------------------------------------
`define RTOM_CLK_PS         8000
`define RTOM_WIN0_PS        12800000
`define RTOM_WIN1_PS        51200000
`define RTOM_WIN2_PS        102400000
`define RTOM_WIN3_PS        204800000
`define RTOM_WIN0_CYC       (`RTOM_WIN0_PS / `RTOM_CLK_PS)

`endif

// file: core/rtom_obs_mux.v
// Observation select multiplexer for the internal evaluation signals
`timescale 1ns/1ps
`include "rtom_regs.vh"

module rtom_obs_mux (
    input  wire [6:0]  observe_select,
    input  wire [12:0] excitation_sample,
    input  wire [12:0] cosine_sample,
    input  wire [12:0] sine_sample,
    input  wire [7:0]  loop_control_variation,
    input  wire [15:0] sumsq_integral,
    input  wire [15:0] sumsq_value,
    input  wire [9:0]  cosine_monitor_offset,
    input  wire [9:0]  sine_monitor_offset,
    output reg  [15:0] obs_data
);

    // ------------------------------------------------------------
    // Selection, upper bits zero filled
    // ------------------------------------------------------------
    always @* begin
        obs_data = 16'h0000;                                          // [R15]
        case (observe_select)                                         // [R3]
            `RTOM_SEL_EXC:    obs_data = {3'h0, excitation_sample};   // [R5]
            `RTOM_SEL_COS:    obs_data = {3'h0, cosine_sample};       // [R5]
            `RTOM_SEL_SIN:    obs_data = {3'h0, sine_sample};         // [R5]
            `RTOM_SEL_CTLVAR: obs_data = {8'h00, loop_control_variation}; // [R6]
            `RTOM_SEL_SQINT:  obs_data = sumsq_integral;              // [R7]
            `RTOM_SEL_SQSUM:  obs_data = sumsq_value;                 // [R8]
            `RTOM_SEL_COSOFS: obs_data = {6'h00, cosine_monitor_offset}; // [R9]
            `RTOM_SEL_SINOFS: obs_data = {6'h00, sine_monitor_offset};   // [R10]
            default:          obs_data = 16'h0000;                    // [R15]
        endcase
    end

endmodule

// file: core/rtom_vel_window.v
// Angular velocity: angle change over a selectable measuring window
`timescale 1ns/1ps
`include "rtom_regs.vh"

module rtom_vel_window #(
    parameter WIN0_CYC = 1600,
    parameter WIN1_CYC = 6400,
    parameter WIN2_CYC = 12800,
    parameter WIN3_CYC = 25600
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [1:0]  velocity_window_select,
    input  wire [15:0] angle_value,
    output reg  [31:0] angular_velocity_value
);

    // ------------------------------------------------------------
    // Window length lookup
    // ------------------------------------------------------------
    function [15:0] win_last;
        input [1:0]  sel;
        reg   [31:0] cyc;
        begin
            case (sel)
                2'b00:   cyc = WIN0_CYC - 1;
                2'b01:   cyc = WIN1_CYC - 1;
                2'b10:   cyc = WIN2_CYC - 1;
                default: cyc = WIN3_CYC - 1;
            endcase
            win_last = cyc[15:0];
        end
    endfunction

    reg  [15:0] win_cnt_ff;
    reg  [15:0] ref_angle_ff;
    wire [15:0] diff = angle_value - ref_angle_ff;
    wire        win_end = (win_cnt_ff >= win_last(velocity_window_select)); // [R1]

    // ------------------------------------------------------------
    // Window counter and difference capture
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt_ff             <= 16'h0000;
            ref_angle_ff           <= 16'h0000;
            angular_velocity_value <= 32'h00000000;
        end else if (win_end) begin
            win_cnt_ff             <= 16'h0000;
            ref_angle_ff           <= angle_value;
            angular_velocity_value <= {{16{diff[15]}}, diff};        // [R14]
        end else begin
            win_cnt_ff             <= win_cnt_ff + 16'h0001;
        end
    end

endmodule

// file: core/rtom_top.v
// Test observation multiplexer with APB register file and timer control
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "rtom_regs.vh"

// Function
// [R1] Two-bit window select picks 12.8, 51.2, 102.4 or 204.8 us velocity window.
// [R2] Reserved observation bits read their reset value; software writes it back.
// [R3] Seven-bit select in bits 22..16 routes one internal signal to data.
// [R4] Selected value appears in data bits 15..0 and on test output pin.
// [R5] Codes 44h, 43h, 42h give excitation, cosine, sine samples in bits 12..0.
// [R6] Code 2Fh gives eight-bit loop control variation in bits 7..0.
// [R7] Code 2Eh gives sixteen-bit sum-of-squares amplitude integral.
// [R8] Code 2Dh gives sixteen-bit sum-of-squares value.
// [R9] Code 1Dh gives ten-bit cosine monitor common offset in bits 9..0.
// [R10] Code 1Ch gives ten-bit sine monitor common offset in bits 9..0.
// [R11] Both registers accept 8, 16 and 32 bit reads and writes.
// [R12] Upper half of observation register resets to zero.
// [R13] Timer control resets to zero; upper writable, lower read-only counter.
// [R14] Velocity output is two's complement angle change over chosen window.
// [R15] Bits above signal width and unlisted codes read zero.
// [R16] Data follows selected signal with one clock latency.
module rtom_top #(
    parameter WIN1_CYC = `RTOM_WIN1_PS / `RTOM_CLK_PS,
    parameter WIN2_CYC = `RTOM_WIN2_PS / `RTOM_CLK_PS,
    parameter WIN3_CYC = `RTOM_WIN3_PS / `RTOM_CLK_PS
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [12:0] excitation_sample,
    input  wire [12:0] cosine_sample,
    input  wire [12:0] sine_sample,
    input  wire [7:0]  loop_control_variation,
    input  wire [15:0] sumsq_integral,
    input  wire [15:0] sumsq_value,
    input  wire [9:0]  cosine_monitor_offset,
    input  wire [9:0]  sine_monitor_offset,
    input  wire [15:0] angle_value,
    input  wire [15:0] timer_count_value,
    output wire [15:0] test_bus_out,
    output wire [31:0] angular_velocity_value,
    output wire [1:0]  zero_cross_pulse_select,
    output wire        timer_zero_cross_source,
    output wire        zero_cross_soft_trigger,
    output wire        compare_enable,
    output wire        interrupt_path_enable,
    output wire        drive_path_enable,
    output wire        sample_trigger_enable,
    output wire        zero_cross_edge_select,
    output wire        counter_run_enable
);

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam WIN0_CYC = `RTOM_WIN0_CYC;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function [31:0] byte_mask;
        input [3:0] strb;
        begin
            byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        end
    endfunction

    function [31:0] merge_word;
        input [31:0] old_val;
        input [31:0] new_val;
        input [31:0] lanes;
        input [31:0] wmask;
        reg   [31:0] m;
        begin
            m          = lanes & wmask;
            merge_word = (old_val & ~m) | (new_val & m);
        end
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg  [31:0] obs_ctl_ff;
    reg  [31:0] nxt_obs_ctl;
    reg  [31:0] etc_ctl_ff;
    reg  [31:0] nxt_etc_ctl;
    reg  [15:0] obs_data_ff;
    reg  [31:0] prdata_ff;
    reg  [31:0] nxt_prdata;
    reg         pready_ff;
    reg         pslverr_ff;
    reg         nxt_pslverr;
    reg         soft_trig_ff;
    reg         nxt_soft_trig;

    wire [15:0] mux_data;
    wire [31:0] lanes;
    wire        setup_phase;
    wire        access_wr;
    wire        hit_obs;
    wire        hit_etc;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign setup_phase = psel & ~penable;
    assign access_wr   = psel & penable & pready_ff & pwrite;
    assign hit_obs     = (paddr == `RTOM_OBS_OFS);
    assign hit_etc     = (paddr == `RTOM_ETC_OFS);
    assign lanes       = byte_mask(pstrb);                             // [R11]

    // ------------------------------------------------------------
    // Observation select
    // ------------------------------------------------------------
    rtom_obs_mux u_obs_mux (
        .observe_select         (obs_ctl_ff[`RTOM_SEL_MSB:`RTOM_SEL_LSB]),
        .excitation_sample      (excitation_sample),
        .cosine_sample          (cosine_sample),
        .sine_sample            (sine_sample),
        .loop_control_variation (loop_control_variation),
        .sumsq_integral         (sumsq_integral),
        .sumsq_value            (sumsq_value),
        .cosine_monitor_offset  (cosine_monitor_offset),
        .sine_monitor_offset    (sine_monitor_offset),
        .obs_data               (mux_data)
    );

    // ------------------------------------------------------------
    // Angular velocity window
    // ------------------------------------------------------------
    rtom_vel_window #(
        .WIN0_CYC (WIN0_CYC),
        .WIN1_CYC (WIN1_CYC),
        .WIN2_CYC (WIN2_CYC),
        .WIN3_CYC (WIN3_CYC)
    ) u_vel_window (
        .pclk                   (pclk),
        .presetn                (presetn),
        .velocity_window_select (obs_ctl_ff[`RTOM_WIN_MSB:`RTOM_WIN_LSB]), // [R1]
        .angle_value            (angle_value),
        .angular_velocity_value (angular_velocity_value)
    );

    // ------------------------------------------------------------
    // Register write logic
    // ------------------------------------------------------------
    always @* begin
        nxt_obs_ctl   = obs_ctl_ff;
        nxt_etc_ctl   = etc_ctl_ff;
        nxt_soft_trig = 1'b0;
        if (access_wr && hit_obs) begin
            // Reserved and data bits are never stored
            nxt_obs_ctl = merge_word(obs_ctl_ff, pwdata, lanes, `RTOM_OBS_WMASK); // [R2]
        end else if (access_wr && hit_etc) begin
            nxt_etc_ctl   = merge_word(etc_ctl_ff, pwdata, lanes, `RTOM_ETC_WMASK); // [R13]
            nxt_soft_trig = pstrb[3] & pwdata[`RTOM_ETC_TRIG_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read data and response
    // ------------------------------------------------------------
    always @* begin
        nxt_prdata  = 32'h00000000;
        nxt_pslverr = 1'b0;
        if (hit_obs) begin
            nxt_prdata = {obs_ctl_ff[31:16], obs_data_ff};              // [R4]
        end else if (hit_etc) begin
            // Trigger bit always reads zero
            nxt_prdata = {etc_ctl_ff[31:16], timer_count_value};       // [R13]
        end else begin
            nxt_pslverr = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            obs_ctl_ff   <= `RTOM_OBS_RST;                              // [R12]
            etc_ctl_ff   <= `RTOM_ETC_RST;                              // [R13]
            soft_trig_ff <= 1'b0;
        end else begin
            obs_ctl_ff   <= nxt_obs_ctl;
            etc_ctl_ff   <= nxt_etc_ctl;
            soft_trig_ff <= nxt_soft_trig;
        end
    end

    // ------------------------------------------------------------
    // Observed data capture
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            obs_data_ff <= 16'h0000;
        end else begin
            obs_data_ff <= mux_data;                                    // [R16]
        end
    end

    // ------------------------------------------------------------
    // APB response registers
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else if (setup_phase) begin
            prdata_ff  <= pwrite ? 32'h00000000 : nxt_prdata;          // [R11]
            pready_ff  <= 1'b1;
            pslverr_ff <= nxt_pslverr;
        end else begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata                  = prdata_ff;
    assign pready                  = pready_ff;
    assign pslverr                 = pslverr_ff;
    assign test_bus_out            = obs_data_ff;                      // [R4]
    assign zero_cross_pulse_select = etc_ctl_ff[`RTOM_ZCP_MSB:`RTOM_ZCP_LSB];
    assign timer_zero_cross_source = etc_ctl_ff[`RTOM_ZSRC_BIT];
    assign zero_cross_soft_trigger = soft_trig_ff;
    assign compare_enable          = etc_ctl_ff[`RTOM_CMP_BIT];
    assign interrupt_path_enable   = etc_ctl_ff[`RTOM_IRQ_BIT];
    assign drive_path_enable       = etc_ctl_ff[`RTOM_DRV_BIT];
    assign sample_trigger_enable   = etc_ctl_ff[`RTOM_SMP_BIT];
    assign zero_cross_edge_select  = etc_ctl_ff[`RTOM_EDGE_BIT];
    assign counter_run_enable      = etc_ctl_ff[`RTOM_RUN_BIT];

endmodule

// file: bench/rtom_top_props.sv
// Port assertions for the observation block
`timescale 1ns/1ps
module rtom_top_chk (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic [15:0] timer_count_value,
    input logic [15:0] test_bus_out,
    input logic [31:0] angular_velocity_value,
    input logic [1:0]  zero_cross_pulse_select,
    input logic        zero_cross_soft_trigger,
    input logic        compare_enable,
    input logic        interrupt_path_enable,
    input logic        drive_path_enable,
    input logic        sample_trigger_enable,
    input logic        zero_cross_edge_select,
    input logic        counter_run_enable
);
    // ----------------------------------------
    // Bus decode and assertions
    // ----------------------------------------
    logic setup;
    logic rd_obs;
    logic wr_etc;
    assign setup  = psel && !penable;
    assign rd_obs = setup && !pwrite && paddr == 12'h064;
    assign wr_etc = psel && penable && pready && pwrite && paddr == 12'h06C;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (setup |=> pready)
        else $error("no ready after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_unmapped: assert property (setup && paddr != 12'h064 && paddr != 12'h06C |=> pslverr)
        else $error("no error on unmapped address");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data outside access");
    a_obs_read: assert property (rd_obs |=> prdata[15:0] == $past(test_bus_out) && prdata[31:30] == 2'h0 && prdata[27:23] == 5'h00)
        else $error("observation read mismatch");
    a_etc_read: assert property (setup && !pwrite && paddr == 12'h06C |=> prdata[15:0] == $past(timer_count_value) && !prdata[24] && prdata[29] == 1'b0 && prdata[27:22] == 6'h00)
        else $error("timer control read mismatch");
    a_trig_pulse: assert property (wr_etc && pstrb[3] && pwdata[24] |=> zero_cross_soft_trigger ##1 !zero_cross_soft_trigger)
        else $error("trigger pulse wrong");
    a_trig_cause: assert property (zero_cross_soft_trigger |-> $past(wr_etc && pstrb[3] && pwdata[24]))
        else $error("trigger without write");
    a_ctl_write: assert property (wr_etc && pstrb[2] |=> {compare_enable, interrupt_path_enable, drive_path_enable, sample_trigger_enable, zero_cross_edge_select, counter_run_enable} == $past(pwdata[21:16]))
        else $error("enables not written");
    a_ctl_hold: assert property (!wr_etc |=> $stable(zero_cross_pulse_select))
        else $error("pulse select changed without write");
    a_vel_sign: assert property (angular_velocity_value[31:16] == {16{angular_velocity_value[15]}})
        else $error("velocity not sign extended");
endmodule

bind rtom_top rtom_top_chk u_chk (.*);

// file: bench/rtom_src_model.sv
// Source model for the internal evaluation signals
`timescale 1ns/1ps
module rtom_src_model (
    input  logic        pclk,
    input  logic        presetn,
    input  logic        advance,
    output logic [12:0] excitation_sample,
    output logic [12:0] cosine_sample,
    output logic [12:0] sine_sample,
    output logic [7:0]  loop_control_variation,
    output logic [15:0] sumsq_integral,
    output logic [15:0] sumsq_value,
    output logic [9:0]  cosine_monitor_offset,
    output logic [9:0]  sine_monitor_offset,
    output logic [15:0] timer_count_value
);
    logic [15:0] pat_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pat_ff <= 16'hB5E3;
        else if (advance)
            pat_ff <= {pat_ff[14:0], pat_ff[15] ^ pat_ff[13] ^ pat_ff[12] ^ pat_ff[10]};
    end
    assign excitation_sample      = pat_ff[12:0];
    assign cosine_sample          = ~pat_ff[15:3];
    assign sine_sample            = pat_ff[13:1] ^ 13'h1ABC;
    assign loop_control_variation = pat_ff[15:8];
    assign sumsq_integral         = ~pat_ff;
    assign sumsq_value            = {pat_ff[7:0], pat_ff[15:8]};
    assign cosine_monitor_offset  = pat_ff[9:0] ^ 10'h2AA;
    assign sine_monitor_offset    = pat_ff[11:2];
    assign timer_count_value      = pat_ff ^ 16'h5A5A;
endmodule

// file: bench/tb.sv
// Self-checking bench for the observation block
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // Signals, design and source model
    // ----------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, advance, er_q;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_q, angular_velocity_value;
    logic [3:0]  pstrb;
    logic [12:0] excitation_sample, cosine_sample, sine_sample;
    logic [7:0]  loop_control_variation;
    logic [15:0] sumsq_integral, sumsq_value, angle_value, timer_count_value, test_bus_out, step;
    logic [9:0]  cosine_monitor_offset, sine_monitor_offset;
    logic [1:0]  zero_cross_pulse_select;
    logic        timer_zero_cross_source, zero_cross_soft_trigger, compare_enable, interrupt_path_enable;
    logic        drive_path_enable, sample_trigger_enable, zero_cross_edge_select, counter_run_enable;
    int          failures, num_checks, i;
    logic [6:0]  codes [10] = '{7'h44, 7'h43, 7'h42, 7'h2F, 7'h2E, 7'h2D, 7'h1D, 7'h1C, 7'h00, 7'h45};
    int          wins [4] = '{1600, 20, 40, 80};
    logic [15:0] steps [4] = '{16'h0001, 16'h0007, 16'hFFFD, 16'h0002};
    logic [31:0] vexp [4] = '{32'h00000640, 32'h0000008C, 32'hFFFFFF88, 32'h000000A0};

    rtom_top #(.WIN1_CYC(20), .WIN2_CYC(40), .WIN3_CYC(80)) u_dut (.*);
    rtom_src_model u_src (.*);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) angle_value <= presetn ? angle_value + step : 16'h0000;

    function automatic logic [15:0] exp_mux(input logic [6:0] c);
        case (c)
            7'h44: exp_mux = {3'h0, excitation_sample};
            7'h43: exp_mux = {3'h0, cosine_sample};
            7'h42: exp_mux = {3'h0, sine_sample};
            7'h2F: exp_mux = {8'h00, loop_control_variation};
            7'h2E: exp_mux = sumsq_integral;
            7'h2D: exp_mux = sumsq_value;
            7'h1D: exp_mux = {6'h00, cosine_monitor_offset};
            7'h1C: exp_mux = {6'h00, sine_monitor_offset};
            default: exp_mux = 16'h0000;
        endcase
    endfunction

    task automatic report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd_q = prdata;
        er_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready timeout", 32'h00000001, {31'h0, pready});
            report_and_stop();
        end
    endtask

    initial begin
        failures = 0;
        num_checks = 0;
        {presetn, psel, penable, pwrite, advance} = 5'b00000;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        step = 16'h0000;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h064, 32'h0, 4'h0);
        chk("obs reset", 32'h00000000, rd_q);
        chk("mapped err", 32'h00000000, {31'h0, er_q});
        apb(1'b0, 12'h06C, 32'h0, 4'h0);
        chk("ctl reset", {16'h0000, timer_count_value}, rd_q);
        apb(1'b0, 12'h068, 32'h0, 4'h0);
        chk("unmapped err", 32'h00000001, {31'h0, er_q});
        apb(1'b1, 12'h064, 32'h307FFFFF, 4'hF);
        apb(1'b0, 12'h064, 32'h0, 4'h0);
        chk("obs reserved", 32'h307F0000, rd_q);
        apb(1'b1, 12'h064, 32'h00420000, 4'h4);
        apb(1'b0, 12'h064, 32'h0, 4'h0);
        chk("obs byte lane", {16'h3042, exp_mux(7'h42)}, rd_q);
        for (i = 0; i < 10; i++) begin
            advance <= 1'b1;
            @(posedge pclk);
            advance <= 1'b0;
            apb(1'b1, 12'h064, {9'h000, codes[i], 16'h0000}, 4'hF);
            apb(1'b0, 12'h064, 32'h0, 4'h0);
            chk("obs data", {9'h000, codes[i], exp_mux(codes[i])}, rd_q);
            chk("test pin", {16'h0000, exp_mux(codes[i])}, {16'h0000, test_bus_out});
        end
        apb(1'b1, 12'h06C, 32'hD13FFFFF, 4'hF);
        apb(1'b0, 12'h06C, 32'h0, 4'h0);
        chk("ctl readback", {16'hD03F, timer_count_value}, rd_q);
        chk("ctl pins", 32'h000001FF, {23'h0, zero_cross_pulse_select, timer_zero_cross_source, compare_enable,
            interrupt_path_enable, drive_path_enable, sample_trigger_enable, zero_cross_edge_select,
            counter_run_enable});
        apb(1'b1, 12'h06C, 32'h0, 4'h3);
        apb(1'b0, 12'h06C, 32'h0, 4'h0);
        chk("ctl low lanes", {16'hD03F, timer_count_value}, rd_q);
        apb(1'b1, 12'h06C, 32'h0, 4'hF);
        for (i = 0; i < 4; i++) begin
            step <= steps[i];
            apb(1'b1, 12'h064, {2'b00, i[1:0], 28'h0}, 4'h8);
            repeat (3 * wins[i] + 10) @(posedge pclk);
            chk("velocity", vexp[i], angular_velocity_value);
        end
        report_and_stop();
    end
endmodule
